/* File: testbench/sbt_far_side.sv */
// far-side model: trigger source, waveform engine, trigger-out load
`timescale 1ns/10ps
`default_nettype none
module sbt_far_side (
  input wire logic clk_i,
  input wire logic drv_en_i,
  input wire logic drv_lvl_i,
  input wire logic run_i,
  input wire logic pin_o_i,
  input wire logic pin_oe_n_i,
  output logic pin_i_o,
  output logic cycle_end_o,
  output int n_cyc_o,
  output int n_hi_o
);
  logic [2:0] ph_q = 3'h0;
  int n_cyc_q = 0;
  int n_hi_q = 0;
  assign n_cyc_o = n_cyc_q;
  assign n_hi_o = n_hi_q;
  // =====================
  // shared line
  // pulses on line
  // line has a pull-down, so a released line reads low, never the last level
  assign pin_i_o = !pin_oe_n_i ? pin_o_i : (drv_en_i ? drv_lvl_i : 1'b0);
  // =====================
  // engine, eight clocks per waveform cycle
  assign cycle_end_o = run_i && (ph_q == 3'h7);
  always @(posedge clk_i) begin
    ph_q <= run_i ? ph_q + 3'h1 : 3'h0;
    n_cyc_q <= n_cyc_q + int'(cycle_end_o);
    n_hi_q <= n_hi_q + int'(pin_i_o);
  end
endmodule
`default_nettype wire

/* File: testbench/sweep_burst_trigger_control_tb.sv */
// self-checking bench for the sweep/burst trigger controller
`timescale 1ns/10ps
`default_nettype none
`include "sbt_defines.svh"
module sweep_burst_trigger_control_tb
  import sbt_pkg::*;
;
  logic clk_i = 1'b0, rst_i = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, serr, pin_in, pin_out, oe_n, led, cyc_end, run, start;
  logic key = 1'b0, drv_en = 1'b0, drv_lvl = 1'b0;
  int n_mismatch = 0, compares = 0, n_start = 0, n_cyc, n_hi;

  initial forever #2.5 clk_i = ~clk_i;

  sbt_trigger_ctrl #(.DEBOUNCE_CYC(4)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .trig_pin_i(pin_in),
    .trig_pin_o(pin_out), .trig_pin_oe_n_o(oe_n), .key_i(key), .key_led_o(led),
    .cycle_end_i(cyc_end), .run_o(run), .start_o(start));

  sbt_far_side FS (
    .clk_i(clk_i), .drv_en_i(drv_en), .drv_lvl_i(drv_lvl), .run_i(run),
    .pin_o_i(pin_out), .pin_oe_n_i(oe_n), .pin_i_o(pin_in),
    .cycle_end_o(cyc_end), .n_cyc_o(n_cyc), .n_hi_o(n_hi));

  always @(posedge clk_i) if (start === 1'b1) n_start <= n_start + 1;

  // =====================
  // helpers
  task automatic tally_and_finish;
    if (n_mismatch == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stuck;
    n_mismatch++;
    $display("[FAIL] %0t got %h exp %h", $time, 1'b0, 1'b1);
    tally_and_finish();
  endtask
  // one access; slave wait length is not assumed
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) stuck();
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  function automatic logic [31:0] cv(sbt_src_type s, sbt_func_type f, logic [8:0] b);
    return {23'h0, b} | 32'(s) | (32'(f) << `SBT_CTRL_FUNC_LSB);
  endfunction
  // waits out the run and any trigger-out pulse
  task automatic idle_wait;
    int n;
    n = 0;
    // a pin edge needs four clocks to show on run
    repeat (6) @(posedge clk_i);
    while ((run !== 1'b0 || pin_in !== 1'b0) && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 2000) stuck();
    repeat (3) @(posedge clk_i);
  endtask
  task automatic pin_pulse;
    drv_lvl <= 1'b1;
    repeat (4) @(posedge clk_i);
    drv_lvl <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  // held well past the shortened debounce
  task automatic press;
    key <= 1'b1;
    repeat (12) @(posedge clk_i);
    key <= 1'b0;
    repeat (12) @(posedge clk_i);
  endtask

  // =====================
  // scenarios
  task automatic t_reset;
    rdc(`SBT_CTRL_OFF, 32'h0);
    rdc(`SBT_PERIOD_OFF, `SBT_PERIOD_RST);
    rdc(`SBT_COUNT_OFF, 32'(`SBT_COUNT_RST));
    wr(`SBT_COUNT_OFF, 32'h0);
    rdc(`SBT_COUNT_OFF, 32'(`SBT_COUNT_MIN));
    wr(`SBT_COUNT_OFF, 32'h0000_ffff);
    rdc(`SBT_COUNT_OFF, 32'(`SBT_COUNT_MAX));
    rdc(12'h020, 32'h0);
    chk(32'(serr), 32'h1);
  endtask
  task automatic t_bus;
    int s0, c0, h0;
    wr(`SBT_COUNT_OFF, 32'h3);
    wr(`SBT_CTRL_OFF, cv(SBT_SRC_BUS, SBT_FUNC_BURST, 9'h008));
    repeat (3) @(posedge clk_i);
    chk(32'(led), 32'h1);
    rdc(`SBT_STATUS_OFF, 32'h11);
    s0 = n_start;
    c0 = n_cyc;
    h0 = n_hi;
    wr(`SBT_CMD_OFF, 32'h1);
    wr(`SBT_CMD_OFF, 32'h1);
    idle_wait();
    chk(32'(n_start - s0), 32'h1);
    chk(32'(n_cyc - c0), 32'h3);
    chk(32'(n_hi - h0 > 200), 32'h1);
  endtask
  task automatic t_ext;
    int s0;
    wr(`SBT_CTRL_OFF, cv(SBT_SRC_EXT, SBT_FUNC_BURST, 9'h008));
    drv_en <= 1'b1;
    @(posedge clk_i);
    chk(32'(oe_n), 32'h1);
    s0 = n_start;
    pin_pulse();
    pin_pulse();
    idle_wait();
    chk(32'(n_start - s0), 32'h1);
    pin_pulse();
    idle_wait();
    chk(32'(n_start - s0), 32'h2);
    wr(`SBT_CTRL_OFF, cv(SBT_SRC_EXT, SBT_FUNC_BURST, 9'h00c));
    drv_lvl <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk(32'(n_start - s0), 32'h2);
    drv_lvl <= 1'b0;
    idle_wait();
    chk(32'(n_start - s0), 32'h3);
    drv_en <= 1'b0;
  endtask
  task automatic t_man;
    int s0, h0;
    wr(`SBT_CTRL_OFF, cv(SBT_SRC_MAN, SBT_FUNC_SWEEP, 9'h008));
    repeat (3) @(posedge clk_i);
    chk(32'(led), 32'h1);
    s0 = n_start;
    h0 = n_hi;
    press();
    idle_wait();
    chk(32'(n_start - s0), 32'h1);
    chk(32'(n_hi - h0 > 200), 32'h1);
    wr(`SBT_CTRL_OFF, cv(SBT_SRC_MAN, SBT_FUNC_SWEEP, 9'h018));
    repeat (2) @(posedge clk_i);
    chk(32'(pin_in), 32'h1);
    wr(`SBT_CTRL_OFF, cv(SBT_SRC_MAN, SBT_FUNC_SWEEP, 9'h108));
    press();
    wr(`SBT_CTRL_OFF, cv(SBT_SRC_MAN, SBT_FUNC_NONE, 9'h008));
    press();
    chk(32'(n_start - s0), 32'h1);
  endtask
  // period of 40 clocks: ten starts and 200 active clocks per 400
  task automatic t_int;
    int s0, h0;
    wr(`SBT_PERIOD_OFF, 32'h28);
    wr(`SBT_CTRL_OFF, cv(SBT_SRC_INT, SBT_FUNC_SWEEP, 9'h008));
    repeat (40) @(posedge clk_i);
    s0 = n_start;
    h0 = n_hi;
    repeat (400) @(posedge clk_i);
    chk(32'(n_start - s0), 32'ha);
    chk(32'(n_hi - h0), 32'hc8);
    wr(`SBT_CTRL_OFF, cv(SBT_SRC_BUS, SBT_FUNC_SWEEP, 9'h000));
    wr(`SBT_CMD_OFF, 32'h2);
    apb(1'b0, `SBT_CTRL_OFF, 32'h0);
    chk({30'h0, rd[1:0]}, 32'h0);
    wr(`SBT_CMD_OFF, 32'h4);
    rdc(`SBT_CTRL_OFF, 32'h0);
    rdc(`SBT_PERIOD_OFF, `SBT_PERIOD_RST);
  endtask
  task automatic t_gate;
    int c0, n;
    wr(`SBT_CTRL_OFF, cv(SBT_SRC_EXT, SBT_FUNC_BURST, 9'h080));
    wr(`SBT_COUNT_OFF, 32'h7);
    rdc(`SBT_COUNT_OFF, 32'h7);
    drv_en <= 1'b1;
    c0 = n_cyc;
    drv_lvl <= 1'b1;
    repeat (100) @(posedge clk_i);
    chk(32'(run), 32'h1);
    chk(32'(n_cyc - c0 > 7), 32'h1);
    drv_lvl <= 1'b0;
    n = 0;
    while (run !== 1'b0 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    chk(32'(n < 14), 32'h1);
    wr(`SBT_CTRL_OFF, cv(SBT_SRC_EXT, SBT_FUNC_BURST, 9'h000));
    c0 = n_cyc;
    pin_pulse();
    idle_wait();
    chk(32'(n_cyc - c0), 32'h7);
    drv_en <= 1'b0;
  endtask

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_bus();
    t_ext();
    t_man();
    t_int();
    t_gate();
    tally_and_finish();
  end
endmodule
`default_nettype wire

/* File: verilog/sbt_defines.svh */
// constants for the sweep/burst trigger controller
`ifndef SBT_DEFINES_SVH
`define SBT_DEFINES_SVH

// ===================== timing
`define SBT_CLK_NS 5
`define SBT_PULSE_NS 1000
`define SBT_PULSE_CYC (`SBT_PULSE_NS / `SBT_CLK_NS + 1)
`define SBT_DEBOUNCE_NS 5000000
`define SBT_DEBOUNCE_CYC (`SBT_DEBOUNCE_NS / `SBT_CLK_NS)

// ===================== register offsets
`define SBT_CTRL_OFF 12'h000
`define SBT_PERIOD_OFF 12'h004
`define SBT_COUNT_OFF 12'h008
`define SBT_CMD_OFF 12'h00c
`define SBT_STATUS_OFF 12'h010

// ===================== control fields
`define SBT_CTRL_SRC_LSB 0
`define SBT_CTRL_SLOPE_BIT 2
`define SBT_CTRL_OUTEN_BIT 3
`define SBT_CTRL_OUTSLOPE_BIT 4
`define SBT_CTRL_FUNC_LSB 5
`define SBT_CTRL_GATED_BIT 7
`define SBT_CTRL_REMOTE_BIT 8

// ===================== command bits
`define SBT_CMD_BUSTRIG_BIT 0
`define SBT_CMD_APPLY_BIT 1
`define SBT_CMD_IFRESET_BIT 2

// ===================== count and reset values
`define SBT_COUNT_INF_BIT 16
`define SBT_COUNT_MIN 16'h0001
`define SBT_COUNT_MAX 16'hc350
`define SBT_COUNT_RST 16'h0001
`define SBT_PERIOD_RST 32'h001e_8480
`define SBT_PERIOD_MIN 32'h0000_0002

`endif

/* File: verilog/sbt_pkg.sv */
// types for the sweep/burst trigger controller
`default_nettype none
package sbt_pkg;

  typedef enum logic [1:0] {
    SBT_SRC_INT,
    SBT_SRC_EXT,
    SBT_SRC_MAN,
    SBT_SRC_BUS
  } sbt_src_type;

  typedef enum logic [1:0] {
    SBT_FUNC_NONE,
    SBT_FUNC_SWEEP,
    SBT_FUNC_BURST,
    SBT_FUNC_RSVD
  } sbt_func_type;

  typedef enum logic [1:0] {
    SBT_ST_IDLE,
    SBT_ST_ARMED,
    SBT_ST_RUN
  } sbt_state_type;

endpackage

`default_nettype wire

/* File: verilog/sbt_sync_edge.sv */
// two-flop synchroniser with edge detection
`timescale 1ns/10ps
`default_nettype none

module sbt_sync_edge (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic d_i,
  output logic lvl_o,
  output logic rise_o,
  output logic fall_o
);

  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign lvl_o = sync_q;
  assign rise_o = sync_q & ~prev_q;
  assign fall_o = ~sync_q & prev_q;

endmodule

`default_nettype wire

/* File: verilog/sbt_trigger_ctrl.sv */
// sweep/burst trigger source selection, sequencing and trigger output
`timescale 1ns/10ps
`default_nettype none
`include "sbt_defines.svh"

module sbt_trigger_ctrl
  import sbt_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYC = `SBT_DEBOUNCE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic trig_pin_i,
  output logic trig_pin_o,
  output logic trig_pin_oe_n_o,
  input wire logic key_i,
  output logic key_led_o,
  input wire logic cycle_end_i,
  output logic run_o,
  output logic start_o
);

  localparam int unsigned PULSE_CYC = `SBT_PULSE_CYC;

  // ==================== registers and state
  logic [8:0] ctrl_q;
  logic [31:0] period_q;
  logic [15:0] count_q;
  logic inf_q;
  sbt_state_type state_q;
  logic [15:0] done_q;
  logic [31:0] tick_cnt_q;
  logic [7:0] pulse_cnt_q;
  logic key_stable_q;
  logic [22:0] deb_cnt_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic trig_out_q;
  logic oe_n_q;
  logic led_q;
  logic run_q;
  logic start_q;

  // ==================== apb decode
  wire setup = psel_i & ~penable_i & ~pready_q;
  wire acc_wr = psel_i & penable_i & pready_q & pwrite_i & ~pslverr_q;
  wire sel_ctrl = paddr_i == `SBT_CTRL_OFF;
  wire sel_period = paddr_i == `SBT_PERIOD_OFF;
  wire sel_count = paddr_i == `SBT_COUNT_OFF;
  wire sel_cmd = paddr_i == `SBT_CMD_OFF;
  wire sel_status = paddr_i == `SBT_STATUS_OFF;
  wire mapped = sel_ctrl | sel_period | sel_count | sel_cmd | sel_status;
  wire wr_ctrl = acc_wr & sel_ctrl;
  wire wr_period = acc_wr & sel_period;
  wire wr_count = acc_wr & sel_count;
  wire wr_cmd = acc_wr & sel_cmd;
  wire cmd_bus = wr_cmd & pwdata_i[`SBT_CMD_BUSTRIG_BIT];
  wire cmd_apply = wr_cmd & pwdata_i[`SBT_CMD_APPLY_BIT];
  wire cmd_ifrst = wr_cmd & pwdata_i[`SBT_CMD_IFRESET_BIT];

  wire sbt_src_type src = sbt_src_type'(ctrl_q[`SBT_CTRL_SRC_LSB +: 2]);
  wire sbt_func_type func = sbt_func_type'(ctrl_q[`SBT_CTRL_FUNC_LSB +: 2]);
  wire slope_fall = ctrl_q[`SBT_CTRL_SLOPE_BIT];
  wire out_en = ctrl_q[`SBT_CTRL_OUTEN_BIT];
  wire out_fall = ctrl_q[`SBT_CTRL_OUTSLOPE_BIT];
  wire gated_burst_select = ctrl_q[`SBT_CTRL_GATED_BIT];
  wire remote = ctrl_q[`SBT_CTRL_REMOTE_BIT];
  wire active = (func == SBT_FUNC_SWEEP) | (func == SBT_FUNC_BURST);
  wire gated = (func == SBT_FUNC_BURST) & gated_burst_select;

  // count clamped into its legal span on write
  wire [15:0] cnt_wr = pwdata_i[15:0];
  wire [15:0] cnt_clamp = (cnt_wr < `SBT_COUNT_MIN) ? `SBT_COUNT_MIN :
                          (cnt_wr > `SBT_COUNT_MAX) ? `SBT_COUNT_MAX : cnt_wr;
  wire [31:0] per_clamp = (pwdata_i < `SBT_PERIOD_MIN) ? `SBT_PERIOD_MIN : pwdata_i;

  wire [31:0] status_word = {11'h000, done_q, led_q, run_q, 1'b0, state_q};
  wire [31:0] rd_mux = sel_ctrl ? {23'h000000, ctrl_q} :
                       sel_period ? period_q :
                       sel_count ? {15'h0000, inf_q, count_q} :
                       sel_status ? status_word : 32'h0000_0000;

  // ==================== inputs
  logic pin_lvl;
  logic pin_rise;
  logic pin_fall;
  logic key_lvl;

  sbt_sync_edge u_pin_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(trig_pin_i),
    .lvl_o(pin_lvl),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  sbt_sync_edge u_key_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(key_i),
    .lvl_o(key_lvl),
    .rise_o(),
    .fall_o()
  );

  wire ext_edge = slope_fall ? pin_fall : pin_rise;
  wire gate_true = slope_fall ? ~pin_lvl : pin_lvl;

  // press once the level has held stable
  wire deb_done = (key_lvl != key_stable_q) & (deb_cnt_q >= 23'(DEBOUNCE_CYC - 1));
  wire key_press = deb_done & key_lvl;

  // ==================== trigger selection
  wire period_tick = tick_cnt_q == 32'h0000_0000;
  // key dropped in remote or inactive function
  wire key_ok = key_press & ~remote & active;
  wire trig_evt = (src == SBT_SRC_INT) ? period_tick :
                  (src == SBT_SRC_EXT) ? ext_edge :
                  (src == SBT_SRC_MAN) ? key_ok : cmd_bus;
  wire last_cycle = (func == SBT_FUNC_SWEEP) | (~inf_q & (done_q + 16'h0001 == count_q));
  wire armed = state_q == SBT_ST_ARMED;

  // ==================== apb and configuration
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~mapped;
      if (setup) begin
        prdata_q <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= 9'h000;
      period_q <= `SBT_PERIOD_RST;
      count_q <= `SBT_COUNT_RST;
      inf_q <= 1'b0;
    end else if (cmd_ifrst) begin
      ctrl_q <= 9'h000;
      period_q <= `SBT_PERIOD_RST;
      count_q <= `SBT_COUNT_RST;
      inf_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= pwdata_i[8:0];
      end else if (cmd_apply) begin
        ctrl_q[`SBT_CTRL_SRC_LSB +: 2] <= SBT_SRC_INT;
      end
      if (wr_period) begin
        period_q <= per_clamp;
      end
      if (wr_count) begin
        count_q <= cnt_clamp;
        inf_q <= pwdata_i[`SBT_COUNT_INF_BIT];
      end
    end
  end

  // ==================== key debounce
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      key_stable_q <= 1'b0;
      deb_cnt_q <= 23'h000000;
    end else if (key_lvl == key_stable_q) begin
      deb_cnt_q <= 23'h000000;
    end else if (deb_done) begin
      key_stable_q <= key_lvl;
      deb_cnt_q <= 23'h000000;
    end else begin
      deb_cnt_q <= deb_cnt_q + 23'h000001;
    end
  end

  // ==================== internal period timer
  // free-running period restarts the run
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_cnt_q <= 32'h0000_0000;
    end else if (src != SBT_SRC_INT | ~active | gated | wr_period | state_q == SBT_ST_IDLE) begin
      tick_cnt_q <= 32'h0000_0000;
    end else if (tick_cnt_q >= period_q - 32'h0000_0001) begin
      tick_cnt_q <= 32'h0000_0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
    end
  end

  // ==================== run sequencer
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= SBT_ST_IDLE;
      done_q <= 16'h0000;
      start_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      unique case (state_q)
        SBT_ST_IDLE: begin
          if (active) begin
            state_q <= SBT_ST_ARMED;
          end
        end
        SBT_ST_ARMED: begin
          done_q <= 16'h0000;
          if (~active) begin
            state_q <= SBT_ST_IDLE;
          end else if (gated) begin
            if (gate_true) begin
              state_q <= SBT_ST_RUN;
              start_q <= 1'b1;
            end
          end else if (trig_evt) begin
            state_q <= SBT_ST_RUN;
            start_q <= 1'b1;
          end
        end
        SBT_ST_RUN: begin
          // triggers not looked at while running
          if (~active) begin
            state_q <= SBT_ST_IDLE;
          end else if (cycle_end_i) begin
            done_q <= done_q + 16'h0001;
            if (gated) begin
              // stop at cycle end once gate false
              if (~gate_true) begin
                state_q <= SBT_ST_ARMED;
              end
            end else if (last_cycle) begin
              state_q <= SBT_ST_ARMED;
            end
          end
        end
      endcase
    end
  end

  // ==================== outputs
  wire man_bus = (src == SBT_SRC_MAN) | (src == SBT_SRC_BUS);
  wire sq_high = tick_cnt_q < {1'b0, period_q[31:1]};
  // square keeps running between runs so the duty stays half the period
  wire int_sq = sq_high & active & ~gated & (state_q != SBT_ST_IDLE);
  wire out_act = (src == SBT_SRC_INT) ? int_sq : (pulse_cnt_q != 8'h00);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pulse_cnt_q <= 8'h00;
    end else if (start_q & man_bus) begin
      pulse_cnt_q <= 8'(PULSE_CYC);
    end else if (pulse_cnt_q != 8'h00) begin
      pulse_cnt_q <= pulse_cnt_q - 8'h01;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      trig_out_q <= 1'b0;
      oe_n_q <= 1'b1;
      led_q <= 1'b0;
      run_q <= 1'b0;
    end else begin
      // external source releases the shared pin
      oe_n_q <= ~(out_en & active & (src != SBT_SRC_EXT));
      // square high first half of period, low first half when out_fall set
      trig_out_q <= out_act ^ out_fall;
      // indicator while armed awaiting key or bus
      led_q <= armed & man_bus & ~gated & active;
      run_q <= (state_q == SBT_ST_RUN) | start_q;
    end
  end

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign trig_pin_o = trig_out_q;
  assign trig_pin_oe_n_o = oe_n_q;
  assign key_led_o = led_q;
  assign run_o = run_q;
  assign start_o = start_q;

  // ==================== checks
  src_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cmd_apply & ~wr_ctrl & ~cmd_ifrst |=> src == SBT_SRC_INT)
    else $error("configure-all left source not internal");

  ifrst_src_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cmd_ifrst |=> ctrl_q == 9'h000 && count_q == `SBT_COUNT_RST)
    else $error("interface reset did not restore defaults");

  ext_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
    armed & active & ~gated & src == SBT_SRC_EXT & ext_edge |=> start_q & state_q == SBT_ST_RUN)
    else $error("external edge did not start a run");

  no_retrig_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == SBT_ST_RUN & ~cycle_end_i & active |=> ~start_q)
    else $error("start during a run");

  key_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
    armed & src == SBT_SRC_MAN & ~gated & (remote | ~active) |=> ~start_q)
    else $error("key accepted in remote or inactive mode");

  burst_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == SBT_ST_RUN & active & ~gated & func == SBT_FUNC_BURST & ~inf_q & cycle_end_i
    & (done_q + 16'h0001 == count_q) |=> armed)
    else $error("burst did not stop at burst count");

  pulse_width_a: assert property (@(posedge clk_i) disable iff (rst_i)
    start_q & man_bus & ~wr_ctrl |=> ##1 (trig_out_q != out_fall) [*8])
    else $error("trigger output pulse too short");

  ext_oe_a: assert property (@(posedge clk_i) disable iff (rst_i)
    src == SBT_SRC_EXT & ~wr_ctrl & ~cmd_ifrst & ~cmd_apply |=> oe_n_q)
    else $error("trigger output driven with external source");

  led_a: assert property (@(posedge clk_i) disable iff (rst_i)
    armed & src == SBT_SRC_BUS & active & ~gated |=> led_q)
    else $error("key indicator off while awaiting bus trigger");

  gate_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == SBT_ST_RUN & gated & ~gate_true & ~cycle_end_i & active |=> state_q == SBT_ST_RUN)
    else $error("gated run stopped before cycle end");

endmodule

`default_nettype wire
